// file: pkg/readback_host_pkg.sv
// Constants shared by the configuration readback host controller
package readback_host_pkg;

  // Command words of the readback set, sent most significant byte first
  localparam logic [31:0] SYNC_WORD      = 32'hAA99_5566;
  localparam logic [31:0] FAR_WRITE_HDR  = 32'h3000_2001;
  localparam logic [31:0] CMD_WRITE_HDR  = 32'h3000_8001;
  localparam logic [31:0] READ_CFG_CMD   = 32'h0000_0004;
  localparam logic [31:0] FRAME_DATA_OUT_REG_READ_HDR  = 32'h2800_6000;
  localparam logic [31:0] TYPE2_READ_HDR = 32'h4800_0000;
  localparam int          TYPE2_COUNT_W  = 27;

  // Byte counts of the command set
  localparam int          SYNC_BYTES     = 4;
  localparam int          CMD_BYTES      = 24;
  localparam int          BYTES_PER_WORD = 4;
  localparam int          IDX_W          = 5;
  localparam logic [IDX_W-1:0] SYNC_FIRST = 5'h00;
  localparam logic [IDX_W-1:0] CMD_FIRST  = 5'h04;
  localparam logic [IDX_W-1:0] CMD_END    = 5'h1C;

  // Link clock: host divides its own clock down to the configuration clock
  localparam int          REF_PERIOD_NS  = 20;
  localparam int          CFG_PERIOD_NS  = 160;
  localparam int          CFG_HALF_CYCLES = CFG_PERIOD_NS / (2 * REF_PERIOD_NS);

  // Abort pattern and idle gap, counted in configuration clock periods
  localparam int          ABORT_EDGES    = 4;
  localparam int          GAP_EDGES      = 2;
  localparam int          EDGE_CNT_W     = 4;

  // Defaults for the smallest logic-block readback
  localparam int          DEF_WORD_COUNT  = 15876;
  localparam int          DEF_FRAME_WORDS = 11;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ABORT,
    ST_WRITE,
    ST_GAP,
    ST_READ
  } host_state_t;

endpackage

// file: rtl/config_clock_gen.sv
// Divider that makes the configuration clock and marks its edges
module config_clock_gen #(
  parameter int HALF_CYCLES = readback_host_pkg::CFG_HALF_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  output logic      config_clock,
  output logic      rise,
  output logic      fall
);

  localparam int CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYCLES - 1);

  logic [CNT_W-1:0] count;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_clock <= 1'b0;
    end else if (count == LAST) begin
      config_clock <= ~config_clock;
    end
  end

  // Strobes are high in the cycle whose edge changes the clock pin
  assign rise = (count == LAST) && !config_clock;
  assign fall = (count == LAST) && config_clock;

endmodule

// file: rtl/config_readback_host.sv
// Host controller that reads logic-block frames back through the byte-wide port
// Notes on behaviour
// RULE_01: Full memory readback needs three sequences; this block runs the logic-block one.
// RULE_02: Verification needs only the logic-block frames; block RAM sections are left out.
// RULE_03: Resync is optional; when asked, abort first, then send the sync word.
// RULE_04: Device ignores a repeated sync word once synchronised.
// RULE_05: Command set without the sync word is exactly 24 bytes.
// RULE_06: Write one word to the frame address register with header 3000 2001h.
// RULE_07: Send the read-configuration command 0000 0004h under header 3000 8001h.
// RULE_08: Type-1 zero-word read header to frame output, then type-2 header with count.
// RULE_09: Device packs bytes into words; misaligned writes require resync.
// RULE_10: Full logic-block readback starts at frame address zero.
// RULE_11: Type-2 header low bits carry the word count; device returns that many.
// RULE_12: Write with select and write strobe low, then release both and the data pins.
// RULE_13: With select low and write high, device drives one byte each rising clock.
// RULE_14: Clock word count times four bytes, then release select; repeatable.
// RULE_15: Readback stream holds only frame contents and pad, no headers or CRC.
// RULE_16: Every frame follows one pad word; the first frame is pad and discarded.
// RULE_17: Readback frames are one word shorter than write frames.
// RULE_18: Total readback bytes equal frame bytes plus pad bytes.
// RULE_19: Verifier drops pad words whole and masks RAM and capture bits.
// RULE_20: Mask covers 32 bits after each frame, not the leading pad and pad frame.
// RULE_21: Mask bit zero means compare, one means skip.
// RULE_22: Device drives data pins only in a read phase; host releases them there.
module config_readback_host #(
  parameter int WORD_COUNT_W = readback_host_pkg::TYPE2_COUNT_W,
  parameter int FRAME_WORDS  = readback_host_pkg::DEF_FRAME_WORDS,
  parameter int HALF_CYCLES  = readback_host_pkg::CFG_HALF_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // User side
  input  wire logic                    start,
  input  wire logic                    resync,
  input  wire logic [31:0]             start_frame,
  input  wire logic [WORD_COUNT_W-1:0] word_count,
  output logic                         busy,
  output logic                         done,
  output logic [7:0]                   rd_byte,
  output logic                         rd_valid,
  output logic                         rd_discard,
  // Device pins
  output logic                         config_clock,
  output logic                         chip_select_n,
  output logic                         write_n,
  output logic [7:0]                   data_out,
  output logic                         data_oe,
  input  wire logic [7:0]              data_in
);

  localparam int TOTAL_W = WORD_COUNT_W + 2;
  localparam int WORD_W  = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS + 1) : 1;
  localparam logic [WORD_W-1:0] GROUP_LAST = WORD_W'(FRAME_WORDS);
  localparam int EDGE_W = readback_host_pkg::EDGE_CNT_W;
  localparam logic [EDGE_W-1:0] ABORT_LAST = EDGE_W'(readback_host_pkg::ABORT_EDGES);
  localparam logic [EDGE_W-1:0] GAP_LAST   = EDGE_W'(readback_host_pkg::GAP_EDGES);

  readback_host_pkg::host_state_t state;

  logic                               clk_rise;
  logic                               clk_fall;
  logic [readback_host_pkg::IDX_W-1:0] byte_idx;
  logic [EDGE_W-1:0]                  edge_cnt;
  logic [31:0]                        far_value;
  logic [WORD_COUNT_W-1:0]            count_value;
  logic [TOTAL_W-1:0]                 read_total;
  logic [TOTAL_W-1:0]                 read_cnt;
  logic                               rise_seen;
  logic [7:0]                         data_meta;
  logic [7:0]                         data_sync;
  logic [1:0]                         byte_in_word;
  logic [WORD_W-1:0]                  word_in_group;
  logic                               first_group;
  logic                               last_capture;

  // Command byte k of the set, most significant byte of each word first
  function automatic logic [7:0] cmd_byte(
    input logic [readback_host_pkg::IDX_W-1:0] idx,
    input logic [31:0]                         frame_address_reg,
    input logic [WORD_COUNT_W-1:0]             count
  );
    logic [31:0] word;
    logic [31:0] type2;
    word  = readback_host_pkg::SYNC_WORD;
    type2 = readback_host_pkg::TYPE2_READ_HDR | 32'(count);
    unique case (idx[4:2])
      3'h0: word = readback_host_pkg::SYNC_WORD;      // RULE_03
      3'h1: word = readback_host_pkg::FAR_WRITE_HDR;  // RULE_06
      3'h2: word = frame_address_reg;                               // RULE_06
      3'h3: word = readback_host_pkg::CMD_WRITE_HDR;  // RULE_07
      3'h4: word = readback_host_pkg::READ_CFG_CMD;   // RULE_07
      3'h5: word = readback_host_pkg::FRAME_DATA_OUT_REG_READ_HDR;  // RULE_08
      3'h6: word = type2;                             // RULE_08
      default: word = 32'h0000_0000;
    endcase
    unique case (idx[1:0])
      2'h0: cmd_byte = word[31:24];
      2'h1: cmd_byte = word[23:16];
      2'h2: cmd_byte = word[15:8];
      default: cmd_byte = word[7:0];
    endcase
  endfunction

  // Edge at which a read byte is taken, half a period after the device drove it
  function automatic logic read_strobe(
    input readback_host_pkg::host_state_t st,
    input logic                           fall,
    input logic                           seen
  );
    read_strobe = (st == readback_host_pkg::ST_READ) && fall && seen;
  endfunction

  config_clock_gen #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_clock (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .config_clock (config_clock),
    .rise         (clk_rise),
    .fall         (clk_fall)
  );

  // Pins from the device pass two flops before use
  // Device delay plus these two flops must fit in half a clock period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  assign busy         = (state != readback_host_pkg::ST_IDLE);
  // A word count of zero would wrap here; it is not supported
  assign last_capture = (read_cnt == read_total - TOTAL_W'(1));

  // Request latch: values held stable for the whole sequence
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      far_value   <= 32'h0000_0000;
      count_value <= '0;
      read_total  <= '0;
    end else if (state == readback_host_pkg::ST_IDLE && start) begin
      far_value   <= start_frame;                               // RULE_01 RULE_02 RULE_10
      count_value <= word_count;                                // RULE_11
      read_total  <= TOTAL_W'({word_count, 2'b00});             // RULE_14
    end
  end

  // Sequencer; all pin changes happen on the falling clock edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state         <= readback_host_pkg::ST_IDLE;
      edge_cnt      <= '0;
      chip_select_n <= 1'b1;
      write_n       <= 1'b1;
      data_out      <= 8'h00;
      data_oe       <= 1'b0;
    end else begin
      unique case (state)
        readback_host_pkg::ST_IDLE: begin
          edge_cnt <= '0;
          if (start) begin
            // Resync runs the abort pattern first, then the sync word
            state <= resync ? readback_host_pkg::ST_ABORT
                            : readback_host_pkg::ST_WRITE;     // RULE_03
          end
        end
        readback_host_pkg::ST_ABORT: begin
          // Write strobe lifted while selected, without a read, aborts the port
          if (clk_fall) begin
            edge_cnt      <= edge_cnt + EDGE_W'(1);
            chip_select_n <= 1'b0;
            data_oe       <= 1'b0;
            write_n       <= (edge_cnt != '0);                  // RULE_03
            if (edge_cnt == ABORT_LAST) begin
              chip_select_n <= 1'b1;
              write_n       <= 1'b1;
              edge_cnt      <= '0;
              state         <= readback_host_pkg::ST_WRITE;
            end
          end
        end
        readback_host_pkg::ST_WRITE: begin
          if (clk_fall) begin
            if (byte_idx == readback_host_pkg::CMD_END) begin
              // Release strobes and data pins before the read phase
              chip_select_n <= 1'b1;                            // RULE_12
              write_n       <= 1'b1;                            // RULE_12
              data_oe       <= 1'b0;                            // RULE_22
              state         <= readback_host_pkg::ST_GAP;
            end else begin
              chip_select_n <= 1'b0;                            // RULE_12
              write_n       <= 1'b0;                            // RULE_12
              data_oe       <= 1'b1;
              data_out      <= cmd_byte(byte_idx, far_value, count_value);
            end
          end
        end
        readback_host_pkg::ST_GAP: begin
          // Released gap lets the device turn its data pins around
          if (clk_fall) begin
            edge_cnt <= edge_cnt + EDGE_W'(1);
            if (edge_cnt == GAP_LAST) begin
              edge_cnt      <= '0;
              chip_select_n <= 1'b0;                            // RULE_13
              write_n       <= 1'b1;                            // RULE_13
              state         <= readback_host_pkg::ST_READ;
            end
          end
        end
        readback_host_pkg::ST_READ: begin
          // Leave select low exactly word count times four rising edges
          if (read_strobe(state, clk_fall, rise_seen) && last_capture) begin
            chip_select_n <= 1'b1;                              // RULE_14
            state         <= readback_host_pkg::ST_IDLE;
          end
        end
        default: state <= readback_host_pkg::ST_IDLE;
      endcase
    end
  end

  // Command set position; the sync word takes the first four bytes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      byte_idx <= '0;
    end else if (state == readback_host_pkg::ST_IDLE && start) begin
      // Skipping the sync word keeps the command set at 24 bytes
      byte_idx <= resync ? readback_host_pkg::SYNC_FIRST
                         : readback_host_pkg::CMD_FIRST;       // RULE_05
    end else if (state == readback_host_pkg::ST_WRITE && clk_fall
                 && byte_idx != readback_host_pkg::CMD_END) begin
      byte_idx <= byte_idx + readback_host_pkg::IDX_W'(1);     // RULE_09
    end
  end

  // Capture is armed only once the device has seen a rising edge while selected
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rise_seen <= 1'b0;
    end else if (state != readback_host_pkg::ST_READ) begin
      rise_seen <= 1'b0;
    end else if (clk_rise) begin
      rise_seen <= 1'b1;
    end
  end

  // One-cycle pulse on the edge that closes the read phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= read_strobe(state, clk_fall, rise_seen) && last_capture;
    end
  end

  // Byte capture half a period after the device drives it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      read_cnt <= '0;
      rd_byte  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state == readback_host_pkg::ST_IDLE) begin
        read_cnt <= '0;
      end else if (read_strobe(state, clk_fall, rise_seen)) begin
        // Bytes pass unmasked so each mask bit lines up with its data bit
        rd_byte  <= data_sync;                                  // RULE_13 RULE_21
        rd_valid <= 1'b1;
        read_cnt <= read_cnt + TOTAL_W'(1);                     // RULE_14
      end
    end
  end

  // Stream position: pad word then a frame, the first group all pad
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      byte_in_word  <= 2'h0;
      word_in_group <= '0;
      first_group   <= 1'b1;
      rd_discard    <= 1'b0;
    end else if (state == readback_host_pkg::ST_IDLE) begin
      byte_in_word  <= 2'h0;
      word_in_group <= '0;
      first_group   <= 1'b1;
    end else if (read_strobe(state, clk_fall, rise_seen)) begin
      rd_discard   <= first_group || (word_in_group == '0);    // RULE_16 RULE_19 RULE_20
      byte_in_word <= byte_in_word + 2'h1;
      if (byte_in_word == 2'h3) begin
        // Group is one pad word plus a readback frame one word short
        if (word_in_group == GROUP_LAST) begin                 // RULE_17
          word_in_group <= '0;
          first_group   <= 1'b0;
        end else begin
          word_in_group <= word_in_group + WORD_W'(1);
        end
      end
    end
  end

endmodule

// file: bench/config_readback_host_properties.sv
// Port-level protocol checks for the configuration readback host
module config_readback_host_properties #(
  parameter int WORD_COUNT_W = 27,
  parameter int FRAME_WORDS  = 11,
  parameter int HALF_CYCLES  = 4
) (
  input wire logic                    ref_clk,
  input wire logic                    reset,
  input wire logic                    start,
  input wire logic                    resync,
  input wire logic [WORD_COUNT_W-1:0] word_count,
  input wire logic                    busy,
  input wire logic                    done,
  input wire logic                    rd_valid,
  input wire logic                    rd_discard,
  input wire logic                    config_clock,
  input wire logic                    chip_select_n,
  input wire logic                    write_n,
  input wire logic                    data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]              n_wr;
  logic [31:0]             n_rd;
  logic                    rs_q;
  logic [WORD_COUNT_W-1:0] wc_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge ref_clk) begin
    if (start && !busy) begin
      rs_q <= resync;
      wc_q <= word_count;
    end
  end
  // Counts restart with each accepted request
  always_ff @(posedge ref_clk) begin
    if (reset || (start && !busy)) n_wr <= 8'h00;
    else if ($rose(config_clock) && data_oe) n_wr <= n_wr + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (reset || (start && !busy)) n_rd <= 32'h0;
    else if (rd_valid) n_rd <= n_rd + 32'h1;
  end
  property p_oe_write; data_oe |-> !chip_select_n && !write_n; endproperty
  a_oe_write: assert property (p_oe_write) else $error("data driven outside write");
  property p_oe_read; !chip_select_n && write_n |-> !data_oe; endproperty
  a_oe_read: assert property (p_oe_read) else $error("host drives in read");
  property p_pins_fall;
    !$past(reset) && ($changed(chip_select_n) || $changed(write_n) || $changed(data_oe))
      |-> $fell(config_clock);
  endproperty
  a_pins_fall: assert property (p_pins_fall) else $error("pin moved off clock fall");
  property p_valid_gap; rd_valid |=> !rd_valid [*7]; endproperty
  a_valid_gap: assert property (p_valid_gap) else $error("bytes closer than a period");
  property p_done_wr; done |-> n_wr == (rs_q ? 8'h1C : 8'h18); endproperty
  a_done_wr: assert property (p_done_wr) else $error("command byte count");
  property p_done_rd; done |-> n_rd + 32'(rd_valid) == 32'(wc_q) * 4; endproperty
  a_done_rd: assert property (p_done_rd) else $error("read byte count");
  property p_first_group; rd_valid && n_rd < 32'(4 * (1 + FRAME_WORDS)) |-> rd_discard; endproperty
  a_first_group: assert property (p_first_group) else $error("pad frame kept");
  property p_idle; !busy |-> chip_select_n && !data_oe; endproperty
  a_idle: assert property (p_idle) else $error("selected while idle");
  property p_done_busy; done |-> !busy ##1 !busy; endproperty
  a_done_busy: assert property (p_done_busy) else $error("busy after done");
  c_resync: cover property (done && rs_q);
  c_plain: cover property (done && !rs_q);
  c_kept: cover property (rd_valid && !rd_discard);
endmodule

bind config_readback_host config_readback_host_properties #(
  .WORD_COUNT_W(WORD_COUNT_W), .FRAME_WORDS(FRAME_WORDS), .HALF_CYCLES(HALF_CYCLES)
) chk_u (
  .ref_clk(ref_clk), .reset(reset), .start(start), .resync(resync),
  .word_count(word_count), .busy(busy), .done(done), .rd_valid(rd_valid),
  .rd_discard(rd_discard), .config_clock(config_clock), .chip_select_n(chip_select_n),
  .write_n(write_n), .data_oe(data_oe)
);

// file: bench/readback_device_model.sv
// Behavioural byte-wide configuration port of the device read back
module readback_device_model (
  input  wire logic       config_clock,
  input  wire logic       chip_select_n,
  input  wire logic       write_n,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_out,
  output logic      [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  wr_q[$];
  logic [31:0] word;
  int          n_byte;
  int          rd_idx;
  bit          synced;
  bit          aborted;
  initial data_in = 8'h00;
  always @(posedge config_clock) begin
    if (!chip_select_n && !write_n) begin
      rd_idx = 0;
      if (data_oe) begin
        wr_q.push_back(data_out);
        word = {word[23:0], data_out};
        n_byte++;
        if (n_byte % 4 == 0 && word == readback_host_pkg::SYNC_WORD) synced = 1;
      end else begin
        // Strobe with no data: abort, alignment lost
        aborted = 1;
        synced = 0;
        n_byte = 0;
        wr_q.delete();
      end
    end else if (!chip_select_n) begin
      data_in <= rd_idx[7:0];
      rd_idx++;
    end
  end
  // No pull resistor: released pins show the inverse of the last byte
  always @(chip_select_n or write_n) begin
    if (chip_select_n || !write_n) data_in = ~data_in;
  end
endmodule

// file: bench/test_config_readback_host.sv
// Self-checking bench for the configuration readback host
module test_config_readback_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FW = 2;
  logic        ref_clk = 0;
  logic        reset = 1;
  logic        start = 0;
  logic        resync = 0;
  logic [31:0] start_frame = 0;
  logic [26:0] word_count = 0;
  logic        busy, done, rd_valid, rd_discard, config_clock;
  logic        chip_select_n, write_n, data_oe;
  logic [7:0]  rd_byte, data_out, data_in;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  config_readback_host #(.FRAME_WORDS(FW)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .start(start), .resync(resync),
    .start_frame(start_frame), .word_count(word_count), .busy(busy), .done(done),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_discard(rd_discard),
    .config_clock(config_clock), .chip_select_n(chip_select_n), .write_n(write_n),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in)
  );
  readback_device_model dev_u (
    .config_clock(config_clock), .chip_select_n(chip_select_n), .write_n(write_n),
    .data_oe(data_oe), .data_out(data_out), .data_in(data_in)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic expect_ok(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic run_readback(input logic rs, input logic [31:0] fr, input logic [26:0] wc);
    logic [31:0] w[$];
    int k;
    bit seen;
    w = {readback_host_pkg::FAR_WRITE_HDR, fr, readback_host_pkg::CMD_WRITE_HDR,
         readback_host_pkg::READ_CFG_CMD, readback_host_pkg::FRAME_DATA_OUT_REG_READ_HDR,
         readback_host_pkg::TYPE2_READ_HDR | 32'(wc)};
    if (rs) w.push_front(readback_host_pkg::SYNC_WORD);
    dev_u.wr_q.delete();
    dev_u.aborted = 0;
    @(negedge ref_clk);
    {start, resync, start_frame, word_count} = {1'b1, rs, fr, wc};
    @(negedge ref_clk);
    start = 0;
    expect_ok(busy === 1'b1, "busy not raised");
    k = 0;
    seen = 0;
    for (int n = 0; n < 20000 && !seen; n++) begin
      @(negedge ref_clk);
      if (rd_valid === 1'b1) begin
        expect_ok(rd_byte === 8'(k), "read byte");
        expect_ok(rd_discard === (k / 4 < FW + 1 || (k / 4) % (FW + 1) == 0), "discard");
        k++;
      end
      seen = (done === 1'b1);
    end
    if (!seen) begin
      n_mismatch++;
      $display("unexpected at %0t: no done", $time);
      complete_run();
    end
    expect_ok(k == wc * 4, "read byte count");
    expect_ok(dev_u.wr_q.size() == w.size() * 4, "command length");
    foreach (dev_u.wr_q[i])
      expect_ok(dev_u.wr_q[i] === w[i / 4][31 - 8 * (i % 4) -: 8], "command byte");
    // Port stays synchronised across runs that skip the sync word
    expect_ok(dev_u.aborted == rs && dev_u.synced == 1'b1, "abort and sync");
    @(negedge ref_clk);
    expect_ok(busy === 1'b0 && chip_select_n === 1'b1 && data_oe === 1'b0, "not idle");
  endtask

  task automatic test_resync_readback();
    run_readback(1'b1, 32'h0000_0000, 27'h9);
    $display("test resync_readback finished");
  endtask

  task automatic test_back_to_back();
    run_readback(1'b0, 32'h0202_0000, 27'h6);
    run_readback(1'b0, 32'h0000_0000, 27'h1);
    $display("test back_to_back finished");
  endtask

  task automatic test_reset_mid_run();
    @(negedge ref_clk);
    {start, resync, word_count} = {1'b1, 1'b0, 27'h9};
    @(negedge ref_clk);
    start = 0;
    repeat (300) @(negedge ref_clk);
    reset = 1;
    @(negedge ref_clk);
    reset = 0;
    expect_ok(chip_select_n === 1'b1 && write_n === 1'b1 && data_oe === 1'b0, "reset pins");
    expect_ok(busy === 1'b0, "busy after reset");
    // Reset cuts the read phase after the full command set; rerun with resync
    run_readback(1'b1, 32'h0000_0000, 27'h3);
    $display("test reset_mid_run finished");
  endtask

  initial begin
    repeat (8) @(negedge ref_clk);
    reset = 0;
    test_resync_readback();
    test_back_to_back();
    test_reset_mid_run();
    complete_run();
  end
endmodule
